//--- gpq_top.sv
// gpq_top: input qualification select, sampling period and direction
// registers of a 64-pin gpio port pair, with an axi4-lite slave.
// assumes mux selection, output latch and peripheral drive come from
// neighbouring blocks on the same clock; pins arrive asynchronously.
//
// Notes on behaviour
// - Each select word covers sixteen pins, two bits per pin at 2n+1:2n.
// - Selector 00 only synchronises the pin to the system clock.
// - Selector 01 qualifies the synchronised input over three samples.
// - Selector 10 qualifies the synchronised input over six samples.
// - Samples are spaced by the sampling period of the pin's group.
// - Selector 11 hands a peripheral the raw pin with no sync at all.
// - Selector 11 on a gpio input behaves exactly as selector 00.
// - Select, period and direction writes land only while protected writes are on.
// - Direction bits steer a pin only while the mux gives it to gpio.
// - A peripheral pin ignores its direction bit; the peripheral drives it.
// - Direction 0 is input (reset), 1 drives the output data latch.
// - Period field 0 gives one clock, N gives 2N clocks, 510 at ff.
//
// The address map and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/100ps
module gpq_top import gpq_pkg::*; (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NPINS-1:0] pin_i,
  output logic [NPINS-1:0] pin_o,
  output logic [NPINS-1:0] pin_oe,
  input wire logic [NPINS-1:0] mux_is_gpio,
  input wire logic [NPINS-1:0] out_latch,
  input wire logic [NPINS-1:0] periph_o,
  input wire logic [NPINS-1:0] periph_oe,
  output logic [NPINS-1:0] gpio_in,
  output logic [NPINS-1:0] periph_in
);
  typedef struct packed {
    logic [31:0] ctrl_a;
    logic [31:0] ctrl_b;
    logic [31:0] qsel_al;
    logic [31:0] qsel_ah;
    logic [31:0] qsel_bl;
    logic [31:0] qsel_bh;
    logic [31:0] dir_a;
    logic [31:0] dir_b;
    logic prot;
    logic [NGRP-1:0][CNT_W-1:0] cnt;
    logic aw_have;
    logic [ADDR_W-1:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } gpq_top_s;

  gpq_top_s s;
  gpq_top_s n;
  logic wr_go;
  logic [NGRP-1:0] tick;
  logic [NGRP-1:0][CNT_W-1:0] reload;
  logic [2*PRD_W*4-1:0] prd_all;
  logic [4*32-1:0] sel_all;
  logic [NPINS-1:0] dir_all;

  // byte-lane merge for a register write
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) r[8*b +: 8] = data[8*b +: 8];
    end
    return r;
  endfunction : merge

  // flat views of the per-pin and per-group fields
  assign prd_all = {s.ctrl_b, s.ctrl_a};
  assign sel_all = {s.qsel_bh, s.qsel_bl, s.qsel_ah, s.qsel_al};
  assign dir_all = {s.dir_b, s.dir_a};

  // per group: reload value and sample strobe
  for (genvar g = 0; g < NGRP; g++) begin : g_grp
    logic [PRD_W-1:0] prd;
    assign prd = prd_all[PRD_W*g +: PRD_W];
    // zero is one clock, else 2N clocks
    assign reload[g] = (prd == 8'h00) ? 9'h000 : ({prd, 1'b0} - 9'h001);
    assign tick[g] = (s.cnt[g] == 9'h000);
  end

  // per pin: qualifier instance and its wiring
  for (genvar i = 0; i < NPINS; i++) begin : g_pin
    gpq_pin_if pin_bus ();
    assign pin_bus.sel = sel_all[SEL_W*i +: SEL_W];
    assign pin_bus.tick = tick[i / GRP_PINS];
    assign pin_bus.raw = pin_i[i];
    assign gpio_in[i] = pin_bus.gpio_val;
    assign periph_in[i] = pin_bus.periph_val;
    gpq_pin_qual u_qual (
      .clk(clk),
      .sys_rst(sys_rst),
      .pif(pin_bus.qual)
    );
  end

  // pad drive: gpio pins follow direction, others the peripheral
  // direction only for gpio pins
  assign pin_oe = (mux_is_gpio & dir_all) | (~mux_is_gpio & periph_oe);
  assign pin_o = (mux_is_gpio & out_latch) | (~mux_is_gpio & periph_o);

  // next state: bus slave, registers, period counters
  always_comb begin
    n = s;
    if (s_axi_awvalid && !s.aw_have) begin
      n.aw_have = 1'b1;
      n.aw_addr = {s_axi_awaddr[ADDR_W-1:2], 2'b00};
    end
    if (s_axi_wvalid && !s.w_have) begin
      n.w_have = 1'b1;
      n.w_data = s_axi_wdata;
      n.w_strb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) n.bvalid = 1'b0;
    // write waits for the previous response to drain
    wr_go = s.aw_have && s.w_have && !s.bvalid;
    if (wr_go) begin
      n.aw_have = 1'b0;
      n.w_have = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_OKAY;
      // guarded words drop writes silently when locked
      case (s.aw_addr)
        OFS_CTRL_A: if (s.prot) n.ctrl_a = merge(s.ctrl_a, s.w_data, s.w_strb);
        OFS_CTRL_B: if (s.prot) n.ctrl_b = merge(s.ctrl_b, s.w_data, s.w_strb);
        OFS_QSEL_AL: if (s.prot) n.qsel_al = merge(s.qsel_al, s.w_data, s.w_strb);
        OFS_QSEL_AH: if (s.prot) n.qsel_ah = merge(s.qsel_ah, s.w_data, s.w_strb);
        OFS_QSEL_BL: if (s.prot) n.qsel_bl = merge(s.qsel_bl, s.w_data, s.w_strb);
        OFS_QSEL_BH: if (s.prot) n.qsel_bh = merge(s.qsel_bh, s.w_data, s.w_strb);
        OFS_DIR_A: if (s.prot) n.dir_a = merge(s.dir_a, s.w_data, s.w_strb);
        OFS_DIR_B: if (s.prot) n.dir_b = merge(s.dir_b, s.w_data, s.w_strb);
        OFS_PROT: begin
          if (s.w_strb[0]) n.prot = s.w_data[PROT_BIT];
        end
        OFS_QIN_A, OFS_QIN_B: n.bresp = RESP_OKAY; // read only, write dropped
        default: n.bresp = RESP_SLVERR;
      endcase
    end
    if (s.rvalid && s_axi_rready) n.rvalid = 1'b0;
    // read answers one cycle after the address is taken
    if (s_axi_arvalid && !s.rvalid) begin
      n.rvalid = 1'b1;
      n.rresp = RESP_OKAY;
      case ({s_axi_araddr[ADDR_W-1:2], 2'b00})
        OFS_CTRL_A: n.rdata = s.ctrl_a;
        OFS_CTRL_B: n.rdata = s.ctrl_b;
        OFS_QSEL_AL: n.rdata = s.qsel_al;
        OFS_QSEL_AH: n.rdata = s.qsel_ah;
        OFS_QSEL_BL: n.rdata = s.qsel_bl;
        OFS_QSEL_BH: n.rdata = s.qsel_bh;
        OFS_DIR_A: n.rdata = s.dir_a;
        OFS_DIR_B: n.rdata = s.dir_b;
        OFS_PROT: n.rdata = {31'h0000_0000, s.prot};
        OFS_QIN_A: n.rdata = gpio_in[31:0];
        OFS_QIN_B: n.rdata = gpio_in[63:32];
        default: begin
          n.rdata = 32'h0000_0000;
          n.rresp = RESP_SLVERR;
        end
      endcase
    end
    for (int g = 0; g < NGRP; g++) begin
      n.cnt[g] = tick[g] ? reload[g] : (s.cnt[g] - 9'h001);
    end
    if (sys_rst) begin
      n = '0;
      n.ctrl_a = CTRL_RST;
      n.ctrl_b = CTRL_RST;
      n.qsel_al = QSEL_RST;
      n.qsel_ah = QSEL_RST;
      n.qsel_bl = QSEL_RST;
      n.qsel_bh = QSEL_RST;
      n.dir_a = DIR_RST;
      n.dir_b = DIR_RST;
      n.prot = PROT_RST;
    end
  end

  always_ff @(posedge clk) begin
    s <= n;
  end

  // bus outputs; ready is simply the empty holding slot
  assign s_axi_awready = !s.aw_have;
  assign s_axi_wready = !s.w_have;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = !s.rvalid;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;

  property p_prot_block;
    @(posedge clk) disable iff (sys_rst)
    (wr_go && !s.prot && s.aw_addr == OFS_DIR_A)
      |=> ($stable(s.dir_a) && s_axi_bvalid && s_axi_bresp == RESP_OKAY);
  endproperty
  a_prot_block: assert property (p_prot_block) else $error("locked write landed");

  property p_qsel_write;
    @(posedge clk) disable iff (sys_rst)
    (wr_go && s.prot && s.aw_addr == OFS_QSEL_AH && s.w_strb[0])
      |=> (g_pin[16].pin_bus.sel == $past(s.w_data[1:0]));
  endproperty
  a_qsel_write: assert property (p_qsel_write) else $error("pin 16 selector not set");

  property p_dir_drive;
    @(posedge clk) disable iff (sys_rst)
    (mux_is_gpio[0] && s.dir_a[0]) |-> (pin_oe[0] && pin_o[0] == out_latch[0]);
  endproperty
  a_dir_drive: assert property (p_dir_drive) else $error("gpio output not driven");

  property p_periph_own;
    @(posedge clk) disable iff (sys_rst)
    (!mux_is_gpio[40]) |-> (pin_oe[40] == periph_oe[40] && pin_o[40] == periph_o[40]);
  endproperty
  a_periph_own: assert property (p_periph_own) else $error("direction leaked to peripheral pin");

  property p_tick_fast;
    @(posedge clk) disable iff (sys_rst)
    (tick[0] && prd_all[7:0] == 8'h00) |=> tick[0];
  endproperty
  a_tick_fast: assert property (p_tick_fast) else $error("period zero not one clock");

  property p_tick_two;
    @(posedge clk) disable iff (sys_rst)
    (tick[1] && prd_all[15:8] == 8'h01) |=> (!tick[1] ##1 tick[1]);
  endproperty
  a_tick_two: assert property (p_tick_two) else $error("period one not two clocks");

  property p_bhold;
    @(posedge clk) disable iff (sys_rst)
    (s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp));
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");

  property p_unmapped;
    @(posedge clk) disable iff (sys_rst)
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h40)
      |=> (s_axi_rvalid && s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
endmodule : gpq_top

//--- gpq_pkg.sv
// gpq_pkg: register map, field layout, reset values and modes of the
// gpio input qualifier and direction block.
// assumes a 32-bit axi4-lite slave port and 64 pins, 8 per sampling group.
package gpq_pkg;
  localparam int NPINS = 64;
  localparam int GRP_PINS = 8;
  localparam int NGRP = 8;
  localparam int ADDR_W = 8;
  localparam int SEL_W = 2;
  localparam int PRD_W = 8;
  localparam int CNT_W = 9;
  localparam int QUAL3_N = 3;
  localparam int QUAL6_N = 6;
  localparam int PROT_BIT = 0;
  // byte offsets of the register words
  localparam logic [ADDR_W-1:0] OFS_CTRL_A = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CTRL_B = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_QSEL_AL = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_QSEL_AH = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_QSEL_BL = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_QSEL_BH = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_DIR_A = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_DIR_B = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_PROT = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_QIN_A = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_QIN_B = 8'h28;
  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] QSEL_RST = 32'h0000_0000;
  localparam logic [31:0] DIR_RST = 32'h0000_0000;
  localparam logic PROT_RST = 1'b0;
  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // per-pin qualification selector codes
  typedef enum logic [SEL_W-1:0] {
    GPQ_SYNC = 2'h0,
    GPQ_QUAL3 = 2'h1,
    GPQ_QUAL6 = 2'h2,
    GPQ_ASYNC = 2'h3
  } gpq_mode_e;
endpackage : gpq_pkg

//--- gpq_pin_if.sv
// gpq_pin_if: one pin's link between the register block and its qualifier.
// assumes clock and reset reach the qualifier as plain ports.
`timescale 1ns/100ps
interface gpq_pin_if;
  logic [1:0] sel;
  logic tick;
  logic raw;
  logic gpio_val;
  logic periph_val;
  modport qual (input sel, input tick, input raw, output gpio_val, output periph_val);
  modport ctrl (output sel, output tick, output raw, input gpio_val, input periph_val);
endinterface : gpq_pin_if

//--- gpq_pin_qual.sv
// gpq_pin_qual: synchroniser and sample qualifier for a single pin.
// assumes raw comes straight from a pad and tick is a one-cycle strobe.
`timescale 1ns/100ps
module gpq_pin_qual import gpq_pkg::*; (
  input wire logic clk,
  input wire logic sys_rst,
  gpq_pin_if.qual pif
);
  typedef struct packed {
    logic [2:0] sync;
    logic level;
    logic [QUAL6_N-1:0] hist;
    logic qual;
  } gpq_pin_s;

  gpq_pin_s s;
  gpq_pin_s n;
  gpq_mode_e mode;
  logic gval;

  assign mode = gpq_mode_e'(pif.sel);

  // next state: sync chain, sample history, qualified level
  always_comb begin
    n = s;
    n.sync = {s.sync[1:0], pif.raw};
    // level moves only when stages two and three agree
    if (s.sync[1] == s.sync[2]) begin
      n.level = s.sync[2];
    end
    if (pif.tick) begin
      n.hist = {s.hist[QUAL6_N-2:0], s.level};
    end
    unique case (mode)
      GPQ_QUAL3: begin
        if (n.hist[QUAL3_N-1:0] == {QUAL3_N{n.hist[0]}}) n.qual = n.hist[0];
      end
      GPQ_QUAL6: begin
        if (n.hist == {QUAL6_N{n.hist[0]}}) n.qual = n.hist[0];
      end
      // tracking keeps a later mode switch glitch free
      GPQ_SYNC, GPQ_ASYNC: n.qual = s.level;
    endcase
    if (sys_rst) n = '0;
  end

  always_ff @(posedge clk) begin
    s <= n;
  end

  // sync-only path, also for gpio under async code
  assign gval = (mode == GPQ_QUAL3 || mode == GPQ_QUAL6) ? s.qual : s.level;
  assign pif.gpio_val = gval;
  // raw pad straight to the peripheral under async code, else the gpio value
  assign pif.periph_val = (mode == GPQ_ASYNC) ? pif.raw : gval;

  property p_sync_only;
    @(posedge clk) disable iff (sys_rst)
    (pif.sel == 2'h0 && s.sync[2] == s.sync[1])
      |=> (pif.sel != 2'h0 || gval == $past(s.sync[2]));
  endproperty
  a_sync_only: assert property (p_sync_only) else $error("sync mode output wrong");

  property p_async;
    @(posedge clk) disable iff (sys_rst)
    (pif.sel == 2'h3) |-> (pif.periph_val == pif.raw && gval == s.level);
  endproperty
  a_async: assert property (p_async) else $error("async mode routing wrong");

  property p_qual3;
    @(posedge clk) disable iff (sys_rst)
    (pif.sel == 2'h1 && $past(pif.sel) == 2'h1 && $changed(s.qual))
      |-> (s.hist[2:0] == {3{s.qual}} && gval == s.qual);
  endproperty
  a_qual3: assert property (p_qual3) else $error("three-sample change early");

  property p_qual6;
    @(posedge clk) disable iff (sys_rst)
    (pif.sel == 2'h2 && $past(pif.sel) == 2'h2 && $changed(s.qual))
      |-> (s.hist == {6{s.qual}});
  endproperty
  a_qual6: assert property (p_qual6) else $error("six-sample change early");
endmodule : gpq_pin_qual

//--- gpq_pad_model.sv
// gpq_pad_model: far side of the pads, asynchronous levels on pin_i.
// assumes the bench calls set_pin; edges land mid-cycle, off the clock.
`timescale 1ns/100ps
module gpq_pad_model (
  input wire logic clk,
  output logic [63:0] pin_i
);
  // idle pads hold a mixed pattern, never all one level
  initial begin
    pin_i = 64'h5a3c_96e1_0ff0_a55a;
  end
  // 3 ns after the edge: pads know nothing of the sampling clock
  task automatic set_pin(input int n, input logic v);
    @(posedge clk);
    #3;
    pin_i[n] = v;
  endtask : set_pin
endmodule : gpq_pad_model

//--- gpio_input_qual_and_direction_tb_top.sv
// gpio_input_qual_and_direction_tb_top: self-checking bench for gpq_top.
// assumes gpq_pkg, gpq_top and gpq_pad_model are compiled before it.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module gpio_input_qual_and_direction_tb_top import gpq_pkg::*;;
  logic clk = 1'h0, sys_rst = 1'h1;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd, wd;
  logic [3:0] s_axi_wstrb = '0;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [63:0] pin_i, pin_o, pin_oe, gpio_in, periph_in;
  logic [63:0] mux_is_gpio = '0, out_latch = '0, periph_o = '0, periph_oe = '0;
  logic [1:0] cm[7] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h1};
  logic [7:0] cf[7] = '{8'h3, 8'h0, 8'h2, 8'h2, 8'h0, 8'h1, 8'hff};
  int fails = 0, comparisons = 0, cyc = 0;

  gpq_top i_dut (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_i, .pin_o,
    .pin_oe, .mux_is_gpio, .out_latch, .periph_o, .periph_oe, .gpio_in, .periph_in);
  gpq_pad_model i_pads (.clk, .pin_i);

  // 100 MHz clock
  always #5 clk = ~clk;

  // hang guard: the whole run needs well under this
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict

  // handshakes judged at the rising edge, before that edge's updates land
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic bh;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      bh = s_axi_bvalid;
      r = s_axi_bresp;
    end while (!bh);
    s_axi_bready <= 1'h0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic h;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      h = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
    end while (!h);
    s_axi_rready <= 1'h0;
  endtask : axi_rd

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e,
                        input logic [1:0] er);
    axi_rd(a, rd, rsp);
    `CHK(nm, e, rd)
    `CHK(nm, er, rsp)
  endtask : rd_chk

  // clocks between samples for a period field
  function automatic int prd(input logic [7:0] f);
    return (f == 8'h0) ? 1 : 2 * f;
  endfunction : prd

  // samples that must agree for a selector
  function automatic int nsmp(input logic [1:0] m);
    return (m == 2'h1) ? 3 : (m == 2'h2) ? 6 : 1;
  endfunction : nsmp

  function automatic logic [63:0] pick(input logic [63:0] s, a, b);
    return (s & a) | (~s & b);
  endfunction : pick

  // one pulse just too short to qualify (long enough for selectors 00 and 11), then a steady level
  task automatic qual_case(input logic [1:0] m, input logic [7:0] f);
    int n, p, k, g, i;
    logic seen;
    n = $urandom_range(63);
    p = prd(f);
    k = nsmp(m);
    g = (k == 1) ? 3 : (k - 1) * p - 1;
    axi_wr(8'h08 + 8'(4 * (n / 16)), {16{m}}, rsp);
    axi_wr(8'(4 * (n / 32)), {4{f}}, rsp);
    i_pads.set_pin(n, 1'h0);
    // the old period may still be counting down, up to 510 clocks
    repeat (k * p + 522) @(posedge clk);
    i_pads.set_pin(n, 1'h1);
    repeat (g - 1) @(posedge clk);
    i_pads.set_pin(n, 1'h0);
    seen = 1'h0;
    repeat (k * p + 10) begin
      @(negedge clk);
      seen |= gpio_in[n];
    end
    `CHK("pulse", (k == 1) ? 1'h1 : 1'h0, seen)
    i_pads.set_pin(n, 1'h1);
    #1;
    if (m == 2'h3) `CHK("periph_in", 1'h1, periph_in[n])
    repeat ((k == 1) ? 2 : (k - 1) * p) @(negedge clk);
    `CHK("early", 1'h0, gpio_in[n])
    i = 0;
    while (gpio_in[n] !== 1'h1 && i < k * p + 8) begin
      @(negedge clk);
      i++;
    end
    `CHK("settle", 1'h1, gpio_in[n])
    `CHK("periph_settle", 1'h1, periph_in[n])
  endtask : qual_case

  initial begin
    wd = $urandom(46867);
    repeat (16) @(posedge clk);
    sys_rst <= 1'h0;
    for (int a = 0; a <= 32; a += 4) rd_chk("reset", 8'(a), 32'h0, RESP_OKAY);
    axi_wr(OFS_QSEL_AH, 32'hffff_ffff, rsp);
    rd_chk("locked", OFS_QSEL_AH, 32'h0, RESP_OKAY);
    axi_wr(OFS_PROT, 32'h1, rsp);
    for (int a = 0; a < 32; a += 4) begin
      wd = $urandom;
      axi_wr(8'(a), wd, rsp);
      rd_chk("rw", 8'(a), wd, RESP_OKAY);
    end
    axi_wr(8'h40, 32'h1, rsp);
    `CHK("bresp", RESP_SLVERR, rsp)
    rd_chk("unmapped", 8'h40, 32'h0, RESP_SLVERR);
    // direction only counts on pins the mux gives to gpio
    for (int t = 0; t < 8; t++) begin
      wd = $urandom;
      axi_wr(OFS_DIR_A, wd, rsp);
      axi_wr(OFS_DIR_B, ~wd, rsp);
      mux_is_gpio <= {$urandom, $urandom};
      out_latch <= {$urandom, $urandom};
      periph_o <= {$urandom, $urandom};
      periph_oe <= {$urandom, $urandom};
      @(negedge clk);
      `CHK("pin_oe", pick(mux_is_gpio, {~wd, wd}, periph_oe), pin_oe)
      `CHK("pin_o", pick(mux_is_gpio, out_latch, periph_o), pin_o)
    end
    axi_wr(OFS_PROT, 32'h0, rsp);
    axi_wr(OFS_DIR_A, ~wd, rsp);
    rd_chk("relock", OFS_DIR_A, wd, RESP_OKAY);
    axi_wr(OFS_PROT, 32'h1, rsp);
    foreach (cm[i]) qual_case(cm[i], cf[i]);
    give_verdict();
  end
endmodule : gpio_input_qual_and_direction_tb_top
